//--- hdl/touch_cmd_defines.svh
/*
 Constants for the touch converter command decoder: command byte fields,
 function codes, data register indices and reset values.
 Assumes it is included by bare name from hdl/ sources.
*/
`ifndef TOUCH_CMD_DEFINES_SVH
`define TOUCH_CMD_DEFINES_SVH

`define FORM_BIT 7
`define FUNC_HI 6
`define FUNC_LO 3
`define RES_BIT 2
`define SOFT_RESET_BIT_BIT 1
`define STOP_BIT 0
`define BIAS_BIT 1
`define DIR_BIT 0

`define FN_SCAN_XYZ 4'h0
`define FN_SCAN_XY 4'h1
`define FN_X 4'h2
`define FN_Y 4'h3
`define FN_Z 4'h4
`define FN_AUX 4'h5
`define FN_TEMP1 4'h6
`define FN_TEMP2 4'h7
`define FN_AUX_CONT 4'h8
`define FN_TEST_X 4'h9
`define FN_TEST_Y 4'hA
`define FN_RESERVED 4'hB
`define FN_SHORT 4'hC
`define FN_DRV_X 4'hD
`define FN_DRV_Y 4'hE
`define FN_DRV_YX 4'hF

`define IDX_X 4'h0
`define IDX_Y 4'h1
`define IDX_Z1 4'h2
`define IDX_Z2 4'h3
`define IDX_AUX 4'h4
`define IDX_TEMP1 4'h5
`define IDX_TEMP2 4'h6
`define IDX_STATUS 4'h7

`define DRV_NONE 2'h0
`define DRV_XX 2'h1
`define DRV_YY 2'h2
`define DRV_YX 2'h3

`define RES_RESET 1'h1
`define RESULT_W 12

`endif

//--- hdl/touch_cmd_pkg.sv
/*
 Types shared by the touch converter command decoder.
 Assumes touch_cmd_defines.svh sits beside it.
*/
`include "touch_cmd_defines.svh"

package touch_cmd_pkg;

    typedef enum logic [3:0] {
        CH_X, CH_Y, CH_Z1, CH_Z2, CH_AUX, CH_T1, CH_T2,
        CH_TX, CH_TY, CH_SHORT, CH_END
    } channel_t;

    // one write into a data register
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [`RESULT_W-1:0] value;
    } data_write_t;

    // one register-access command
    typedef struct packed {
        logic writeValid;
        logic readAddrLoad;
        logic [3:0] index;
    } reg_access_t;

endpackage

//--- hdl/sync_bits.sv
/*
 Two-flop synchroniser with a rising-edge pulse on the synced level.
 Assumes inputs arrive from outside the clock domain.
*/
`timescale 1ns/100ps
`default_nettype none

module sync_bits
#(
    parameter int W = 1
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    // stage1 feeds stage2 only; edges are taken after the second flop
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    assign level = stage2;
    assign rise = stage2 & ~stage3;
endmodule

`default_nettype wire

//--- hdl/touch_converter_command_decoder.sv
/*
 Command decoder of the touch converter: takes command bytes from the
 serial-bus slave and sequences converter functions.
 Assumes cmdValid/cmdByte and seqReadBusy come from same-clock logic;
 pen, done and pass come from the analog side and are synchronised here.
*/
// How it works
// - bit 7 chooses conversion or register form
// - bits 6..3 are the function code
// - code 0 scans XYZ1Z2 until lift/stop
// - code 1 scans XY until lift/stop
// - codes 2,3,4 convert X, Y, Z once
// - code 5 aux once, code 8 continuous
// - codes 6,7 store temperature results
// - X connection test drives pen irq
// - Y connection test drives pen irq
// - reserved code condition cleared by stop
// - short test reported on irq, status
// - short test needs all range bits set
// - codes 13..15 select driver settings
// - soft reset restores defaults, self clears
// - stop aborts running function, self clears
// - armed scan starts itself on touch
// - no stored scan code means wait
// - stored scan code reused while mode set
// - no data updates during sequential read
// - resolution bit: one 12, zero 10 bits
// - register form: write or set read start
// - bias kept between conversions when set
// - stop powers down the converter
`timescale 1ns/100ps
`default_nettype none
`include "touch_cmd_defines.svh"

module touch_converter_command_decoder
#(
    parameter int RANGE_W = 2
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmdValid,
    input wire logic [7:0] cmdByte,
    input wire logic seqReadBusy,
    input wire logic scanControlMode,
    input wire logic [RANGE_W-1:0] panelResistanceRange,
    input wire logic penTouchPin,
    input wire logic convDonePin,
    input wire logic testPassPin,
    input wire logic [`RESULT_W-1:0] convData,
    output logic resolutionSelect,
    output logic softResetPulse,
    output logic convStart,
    output touch_cmd_pkg::channel_t convChannel,
    output logic biasOn,
    output logic penIrqDataReadyOut,
    output touch_cmd_pkg::data_write_t dataWrite,
    output touch_cmd_pkg::reg_access_t regAccess,
    output logic [1:0] driverSelect,
    output logic statusTestPass,
    output logic functionBusy
);
    // the range test needs at least one bit to reduce
    if (RANGE_W < 1)
    begin : g_bad_range
        $error("RANGE_W must be at least 1");
    end

    typedef enum {ST_IDLE, ST_ARMED, ST_START, ST_WAIT, ST_STORE,
        ST_FAULT} state_t;

    state_t state_reg;
    touch_cmd_pkg::channel_t chan_reg;
    logic [3:0] func_reg;
    logic [3:0] armedFunc_reg;
    logic armed_reg;
    logic biasKeep_reg;
    logic reservedHold_reg;
    logic [`RESULT_W-1:0] result_reg;
    logic pass_reg;
    logic [2:0] syncLevel;
    logic [2:0] syncRise;
    logic penDown;
    logic doneRise;
    logic passLevel;

    sync_bits #(.W(3)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din({testPassPin, convDonePin, penTouchPin}),
        .level(syncLevel),
        .rise(syncRise)
    );
    assign penDown = syncLevel[0];
    assign doneRise = syncRise[1];
    assign passLevel = syncLevel[2];

    // first channel of each converting function code
    function automatic touch_cmd_pkg::channel_t firstChannel(
        input logic [3:0] fn);
        case (fn)
            `FN_SCAN_XYZ, `FN_SCAN_XY, `FN_X: firstChannel = touch_cmd_pkg::CH_X;
            `FN_Y: firstChannel = touch_cmd_pkg::CH_Y;
            `FN_Z: firstChannel = touch_cmd_pkg::CH_Z1;
            `FN_AUX, `FN_AUX_CONT: firstChannel = touch_cmd_pkg::CH_AUX;
            `FN_TEMP1: firstChannel = touch_cmd_pkg::CH_T1;
            `FN_TEMP2: firstChannel = touch_cmd_pkg::CH_T2;
            `FN_TEST_X: firstChannel = touch_cmd_pkg::CH_TX;
            `FN_TEST_Y: firstChannel = touch_cmd_pkg::CH_TY;
            `FN_SHORT: firstChannel = touch_cmd_pkg::CH_SHORT;
            default: firstChannel = touch_cmd_pkg::CH_END;
        endcase
    endfunction

    // channel after the current one; CH_END closes one pass
    function automatic touch_cmd_pkg::channel_t nextChannel(
        input logic [3:0] fn, input touch_cmd_pkg::channel_t ch);
        nextChannel = touch_cmd_pkg::CH_END;
        if (ch == touch_cmd_pkg::CH_X && (fn == `FN_SCAN_XYZ || fn == `FN_SCAN_XY))
            nextChannel = touch_cmd_pkg::CH_Y;
        else if (ch == touch_cmd_pkg::CH_Y && fn == `FN_SCAN_XYZ)
            nextChannel = touch_cmd_pkg::CH_Z1;
        else if (ch == touch_cmd_pkg::CH_Z1)
            nextChannel = touch_cmd_pkg::CH_Z2;
    endfunction

    // data register index of a measuring channel
    function automatic logic [3:0] dataIndex(
        input touch_cmd_pkg::channel_t ch);
        case (ch)
            touch_cmd_pkg::CH_X: dataIndex = `IDX_X;
            touch_cmd_pkg::CH_Y: dataIndex = `IDX_Y;
            touch_cmd_pkg::CH_Z1: dataIndex = `IDX_Z1;
            touch_cmd_pkg::CH_Z2: dataIndex = `IDX_Z2;
            touch_cmd_pkg::CH_AUX: dataIndex = `IDX_AUX;
            touch_cmd_pkg::CH_T1: dataIndex = `IDX_TEMP1;
            touch_cmd_pkg::CH_T2: dataIndex = `IDX_TEMP2;
            default: dataIndex = `IDX_STATUS;
        endcase
    endfunction

    logic isConv;
    logic isReg;
    logic [3:0] cmdFunc;
    logic stopCmd;
    logic swrstCmd;
    logic isTestCh;
    logic isScanFn;
    logic passEnd;
    logic rangeAll;
    assign isConv = cmdValid && cmdByte[`FORM_BIT];
    assign isReg = cmdValid && !cmdByte[`FORM_BIT];
    assign cmdFunc = cmdByte[`FUNC_HI:`FUNC_LO];
    assign stopCmd = isConv && cmdByte[`STOP_BIT];
    assign swrstCmd = isConv && cmdByte[`SOFT_RESET_BIT_BIT];
    assign isTestCh = chan_reg == touch_cmd_pkg::CH_TX
        || chan_reg == touch_cmd_pkg::CH_TY
        || chan_reg == touch_cmd_pkg::CH_SHORT;
    assign isScanFn = func_reg == `FN_SCAN_XYZ || func_reg == `FN_SCAN_XY;
    assign passEnd = nextChannel(func_reg, chan_reg) == touch_cmd_pkg::CH_END;
    assign rangeAll = &panelResistanceRange;

    // function sequencer; soft reset and stop win over a new code
    always_ff @(posedge clock)
    begin
        convStart <= 1'b0;
        if (sys_rst || swrstCmd)
        begin
            state_reg <= ST_IDLE;
            chan_reg <= touch_cmd_pkg::CH_END;
            func_reg <= `FN_SCAN_XYZ;
            convStart <= 1'b0;
        end
        else if (stopCmd)
        begin
            state_reg <= ST_IDLE;
            chan_reg <= touch_cmd_pkg::CH_END;
        end
        // a failed test ignores new codes until stop
        else if (isConv && state_reg != ST_FAULT
            && firstChannel(cmdFunc) != touch_cmd_pkg::CH_END)
        begin
            func_reg <= cmdFunc;
            chan_reg <= firstChannel(cmdFunc);
            if ((cmdFunc == `FN_SCAN_XYZ || cmdFunc == `FN_SCAN_XY) && !penDown)
                state_reg <= ST_ARMED;
            // short test skipped outside full range
            else if (cmdFunc == `FN_SHORT && !rangeAll)
                state_reg <= ST_IDLE;
            else
                state_reg <= ST_START;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (armed_reg && scanControlMode && penDown)
                    begin
                        func_reg <= armedFunc_reg;
                        chan_reg <= touch_cmd_pkg::CH_X;
                        state_reg <= ST_START;
                    end
                end
                ST_ARMED:
                begin
                    if (penDown)
                        state_reg <= ST_START;
                end
                ST_START:
                begin
                    convStart <= 1'b1;
                    state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (doneRise)
                        state_reg <= ST_STORE;
                end
                ST_STORE:
                begin
                    if (isTestCh && !pass_reg)
                        state_reg <= ST_FAULT;
                    // hold the update during a sequential read
                    else if (isTestCh || (!seqReadBusy && !cmdValid))
                    begin
                        if (!passEnd)
                        begin
                            chan_reg <= nextChannel(func_reg, chan_reg);
                            state_reg <= ST_START;
                        end
                        else if (isScanFn && penDown)
                        begin
                            chan_reg <= touch_cmd_pkg::CH_X;
                            state_reg <= ST_START;
                        end
                        else if (func_reg == `FN_AUX_CONT)
                            state_reg <= ST_START;
                        else
                            state_reg <= ST_IDLE;
                    end
                end
                ST_FAULT:
                begin
                    state_reg <= ST_FAULT;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // sample converter result when the done edge is seen
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            result_reg <= '0;
            pass_reg <= 1'b0;
        end
        else if (state_reg == ST_WAIT && doneRise)
        begin
            result_reg <= convData;
            pass_reg <= passLevel;
        end
    end

    // results go to the channel's data register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            dataWrite <= '0;
        else
        begin
            dataWrite.valid <= state_reg == ST_STORE && !isTestCh
                && !seqReadBusy && !stopCmd && !swrstCmd && !cmdValid;
            dataWrite.index <= dataIndex(chan_reg);
            dataWrite.value <= result_reg;
        end
    end

    // stored scan code kept only while mode stays one
    always_ff @(posedge clock)
    begin
        if (sys_rst || swrstCmd || stopCmd || !scanControlMode)
        begin
            armed_reg <= 1'b0;
            armedFunc_reg <= `FN_SCAN_XYZ;
        end
        else if (isConv && (cmdFunc == `FN_SCAN_XYZ || cmdFunc == `FN_SCAN_XY))
        begin
            armed_reg <= 1'b1;
            armedFunc_reg <= cmdFunc;
        end
    end

    // pen irq low during and after a failed test
    always_ff @(posedge clock)
    begin
        if (sys_rst || swrstCmd)
        begin
            penIrqDataReadyOut <= 1'b1;
            statusTestPass <= 1'b0;
        end
        // stop releases the pin but keeps the last test result
        else if (stopCmd)
            penIrqDataReadyOut <= 1'b1;
        else if (state_reg != ST_FAULT && state_reg != ST_IDLE && isTestCh)
        begin
            penIrqDataReadyOut <= state_reg == ST_STORE && pass_reg;
            if (state_reg == ST_STORE)
                statusTestPass <= pass_reg;
        end
        else if (state_reg == ST_IDLE)
            penIrqDataReadyOut <= 1'b1;
    end

    // driver settings; reserved condition held until stop
    always_ff @(posedge clock)
    begin
        if (sys_rst || swrstCmd)
        begin
            driverSelect <= `DRV_NONE;
            reservedHold_reg <= 1'b0;
        end
        else if (stopCmd)
            reservedHold_reg <= 1'b0;
        else if (isConv)
        begin
            case (cmdFunc)
                `FN_DRV_X: driverSelect <= `DRV_XX;
                `FN_DRV_Y: driverSelect <= `DRV_YY;
                `FN_DRV_YX: driverSelect <= `DRV_YX;
                `FN_RESERVED: reservedHold_reg <= 1'b1;
                default: driverSelect <= `DRV_NONE;
            endcase
        end
    end

    // resolution; soft reset pulse lasts one cycle
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            resolutionSelect <= `RES_RESET;
            softResetPulse <= 1'b0;
        end
        else
        begin
            softResetPulse <= swrstCmd;
            if (swrstCmd)
                resolutionSelect <= `RES_RESET;
            else if (isConv)
                resolutionSelect <= cmdByte[`RES_BIT];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            regAccess <= '0;
        else
        begin
            regAccess.writeValid <= isReg && !cmdByte[`DIR_BIT];
            regAccess.readAddrLoad <= isReg && cmdByte[`DIR_BIT];
            if (isReg)
                regAccess.index <= cmdByte[`FUNC_HI:`FUNC_LO];
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst || swrstCmd || stopCmd)
        begin
            biasKeep_reg <= 1'b0;
            biasOn <= 1'b0;
        end
        else
        begin
            if (isReg)
                biasKeep_reg <= cmdByte[`BIAS_BIT];
            biasOn <= state_reg == ST_START || state_reg == ST_WAIT
                || (biasKeep_reg && state_reg == ST_STORE);
        end
    end

    // channel and busy follow the sequencer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            convChannel <= touch_cmd_pkg::CH_END;
            functionBusy <= 1'b0;
        end
        else
        begin
            convChannel <= chan_reg;
            functionBusy <= reservedHold_reg
                || (state_reg != ST_IDLE && state_reg != ST_ARMED);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_stop_aborts: assert property (
        stopCmd |=> state_reg == ST_IDLE ##1 !functionBusy && !biasOn)
        else $error("stop did not abort the function");
    a_stop_powers: assert property (
        stopCmd |=> !biasOn)
        else $error("stop left bias on");
    a_soft_reset_bit_pulse: assert property (
        swrstCmd ##1 !swrstCmd |-> softResetPulse ##1 !softResetPulse)
        else $error("soft reset pulse not one cycle");
    a_hold_seqread: assert property (
        seqReadBusy |=> !dataWrite.valid)
        else $error("data write during sequential read");
    a_fault_holds: assert property (
        state_reg == ST_FAULT && !stopCmd && !swrstCmd |=>
        !penIrqDataReadyOut)
        else $error("failed test released pen irq without stop");
    a_test_irq_low: assert property (
        state_reg == ST_WAIT && isTestCh && !stopCmd && !swrstCmd
        |=> !penIrqDataReadyOut)
        else $error("pen irq high during test");
    a_reg_decode: assert property (
        isReg |=> regAccess.writeValid != regAccess.readAddrLoad
        && regAccess.index == $past(cmdByte[`FUNC_HI:`FUNC_LO]))
        else $error("register form decoded wrongly");
    a_res_follow: assert property (
        isConv && !swrstCmd |=> resolutionSelect == $past(cmdByte[`RES_BIT]))
        else $error("resolution bit not taken");
    a_start_conv: assert property (
        state_reg == ST_START && !cmdValid |=> convStart
        && state_reg == ST_WAIT)
        else $error("converter not started");
    a_short_range: assert property (
        isConv && !stopCmd && !swrstCmd && cmdFunc == `FN_SHORT
        && !rangeAll && state_reg != ST_FAULT |=> state_reg == ST_IDLE)
        else $error("short test ran outside full range");
    a_single_idle: assert property (
        state_reg == ST_STORE && func_reg == `FN_X && !isTestCh
        && !seqReadBusy && !cmdValid |=> state_reg == ST_IDLE)
        else $error("single shot did not return to idle");

    c_scan_loop: cover property (
        state_reg == ST_STORE && isScanFn && passEnd && penDown);
    c_test_fail: cover property (state_reg == ST_FAULT);
    c_auto_start: cover property (state_reg == ST_IDLE && armed_reg
        && scanControlMode && penDown);
    c_held_write: cover property (state_reg == ST_STORE && seqReadBusy
        && !isTestCh);
endmodule

`default_nettype wire

//--- tb/conv_model.sv
/*
 Converter side model: answers each start strobe with a done pulse.
 Assumes the decoder clock for the strobe, a free link clock otherwise.
*/
`timescale 1ns/100ps
`default_nettype none

module conv_model
(
    input wire logic clock,
    input wire logic linkClk,
    input wire logic convStart,
    input wire logic [3:0] chan,
    input wire logic passIn,
    input wire logic [7:0] lat,
    output logic donePin,
    output logic passPin,
    output logic [11:0] data
);
    int ph = 0;
    int cnt = 0;

    initial
    begin
        donePin = 1'b0;
        passPin = 1'b0;
        data = 12'h000;
    end

    // a new start drops done, so every result gets its own edge
    always @(posedge clock)
    begin
        if (convStart)
        begin
            ph = 1;
            cnt = lat;
            #1 donePin = 1'b0;
        end
    end

    // result held while done is high, scrambled once it is released
    always @(posedge linkClk)
    begin
        #1;
        if (cnt > 0)
            cnt = cnt - 1;
        else if (ph == 1)
        begin
            ph = 2;
            cnt = 3;
            data = {8'hA5, chan};
            passPin = passIn;
            donePin = 1'b1;
        end
        else if (ph == 2)
        begin
            ph = 0;
            donePin = 1'b0;
            data = ~data;
        end
    end
endmodule

`default_nettype wire

//--- tb/touch_converter_command_decoder_bench.sv
/*
 Self-checking bench for the touch converter command decoder.
 Assumes conv_model answers conversions on an 80 ns link clock.
*/
`timescale 1ns/100ps
`default_nettype none

module touch_converter_command_decoder_bench;
    logic clock = 1'b0;
    logic linkClk = 1'b0;
    logic sysRst = 1'b1;
    logic cmdValid = 1'b0;
    logic [7:0] cmdByte = 8'h00;
    logic seqReadBusy = 1'b0;
    logic scanMode = 1'b0;
    logic [1:0] range = 2'h3;
    logic pen = 1'b0;
    logic passIn = 1'b1;
    logic [7:0] lat = 8'h02;
    logic [31:0] seed = 32'h311A;
    logic done, pass, resSel, srPulse, start, bias, irq, tPass, busy;
    logic [11:0] data;
    logic [1:0] drv;
    logic [15:0] want;
    touch_cmd_pkg::channel_t chan;
    touch_cmd_pkg::data_write_t dw;
    touch_cmd_pkg::reg_access_t ra;
    logic [15:0] expQ[$];
    int failures = 0;
    int n_checks = 0;

    touch_converter_command_decoder #(.RANGE_W(2)) dut
    (
        .clock(clock), .sys_rst(sysRst), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .seqReadBusy(seqReadBusy),
        .scanControlMode(scanMode), .panelResistanceRange(range),
        .penTouchPin(pen), .convDonePin(done), .testPassPin(pass),
        .convData(data), .resolutionSelect(resSel),
        .softResetPulse(srPulse), .convStart(start), .convChannel(chan),
        .biasOn(bias), .penIrqDataReadyOut(irq), .dataWrite(dw),
        .regAccess(ra), .driverSelect(drv), .statusTestPass(tPass),
        .functionBusy(busy)
    );

    conv_model model
    (
        .clock(clock), .linkClk(linkClk), .convStart(start), .chan(chan),
        .passIn(passIn), .lat(lat), .donePin(done), .passPin(pass),
        .data(data)
    );

    // model changes land 1 ns after a link edge, between clock edges
    initial forever #4 clock = ~clock;
    initial
    begin
        #1;
        forever #40 linkClk = ~linkClk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // callers leave a tick between two sends so valid never glitches
    task automatic send(input logic [7:0] b);
        cmdValid = 1'b1;
        cmdByte = b;
        tick(1);
        cmdValid = 1'b0;
    endtask

    // channel codes follow the data register order
    task automatic expect_w(input logic [3:0] i);
        expQ.push_back({i, 8'hA5, i});
    endtask

    task automatic drain();
        for (int i = 0; i < 2000 && expQ.size() > 0; i++)
            tick(1);
        check(16'(expQ.size()), 16'h0000);
    endtask

    task automatic end_sim();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // scoreboard: a write with no note pending compares against FFFF
    always @(posedge clock)
    begin
        if (dw.valid === 1'b1)
        begin
            want = expQ.size() > 0 ? expQ.pop_front() : 16'hFFFF;
            check({dw.index, dw.value}, want);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        end_sim();
    end

    initial
    begin
        tick(3);
        sysRst = 1'b0;
        check({irq, resSel, busy, drv}, 16'h0018);
        check(chan, touch_cmd_pkg::CH_END);
        // single shots, prompt and slow converter answers
        pen = 1'b1;
        for (int c = 2; c < 8; c++)
        begin
            // at least one link period so done is seen to fall
            lat = 8'(rnd() & 32'h7) + 8'h01;
            expect_w(4'(c < 5 ? c - 2 : c - 1));
            if (c == 4)
                expect_w(4'h3);
            tick(1);
            send({1'b1, 4'(c), 3'b100});
            drain();
            tick(2);
            check(busy, 1'b0);
        end
        $display("single shot test done");
        // continuous XY scan; a sequential read holds writes back
        lat = 8'h08;
        seqReadBusy = 1'b1;
        expect_w(4'h0);
        expect_w(4'h1);
        send(8'h8C);
        tick(300);
        check(16'(expQ.size()), 16'h0002);
        seqReadBusy = 1'b0;
        drain();
        send(8'h81);
        tick(200);
        check({bias, busy}, 16'h0000);
        $display("xy scan test done");
        // armed XYZ scan starts on touch, code kept for the next one
        pen = 1'b0;
        scanMode = 1'b1;
        tick(3);
        send(8'h84);
        tick(200);
        check(busy, 1'b0);
        // a pass in flight when the pen lifts still completes
        for (int t = 0; t < 2; t++)
        begin
            for (int i = 0; i < 8; i++)
                expect_w(4'(i % 4));
            pen = 1'b1;
            for (int i = 0; i < 2000 && expQ.size() > 4; i++)
                tick(1);
            pen = 1'b0;
            drain();
            tick(20);
        end
        scanMode = 1'b0;
        send(8'h81);
        $display("armed scan test done");
        // connection tests with good and bad results, short test failing and outside full range
        for (int k = 0; k < 6; k++)
        begin
            passIn = k[0];
            range = k == 5 ? 2'h0 : 2'h3;
            tick(1);
            send({1'b1, k < 2 ? 4'h9 : k < 4 ? 4'hA : 4'hC, 3'b100});
            tick(1);
            check(irq, k == 5);
            tick(100);
            check(irq, k == 5 || k[0]);
            if (k < 5)
                check(tPass, k[0]);
            send(8'h81);
            tick(1);
            check(irq, 1'b1);
            if (k < 5)
                check(tPass, k[0]);
        end
        send(8'hDC);
        tick(2);
        check(busy, 1'b1);
        send(8'h81);
        tick(1);
        check(busy, 1'b0);
        $display("test functions done");
        // driver settings with a random resolution bit
        for (int d = 1; d < 4; d++)
        begin
            logic rm;
            rm = 1'(rnd());
            tick(1);
            send({1'b1, 4'(12 + d), rm, 2'b00});
            check({drv, resSel}, {2'(d), rm});
        end
        // register form: write strobe or read start, random index
        for (int r = 0; r < 4; r++)
        begin
            logic [4:0] a;
            a = 5'(rnd());
            tick(1);
            send({1'b0, a[4:1], 2'b00, a[0]});
            check(ra, {~a[0], a[0], a[4:1]});
        end
        $display("register form test done");
        // soft reset: one pulse out, defaults back
        tick(1);
        send(8'hE8);
        tick(1);
        send(8'h82);
        for (int i = 0; i < 3 && srPulse !== 1'b1; i++)
            tick(1);
        check(srPulse, 1'b1);
        tick(2);
        check({resSel, drv}, 3'b100);
        $display("soft reset test done");
        tick(5);
        end_sim();
    end
endmodule

`default_nettype wire
